// file: verilog/ampctl_top.sv
// Two-wire register target plus protection
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module ampctl_top #(
    // Bus target address, value arbitrary
    parameter logic [6:0] DEV_ADDR = 7'h2A
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic ocp_flag,
    input wire logic otp_flag,
    input wire logic supply_ok,
    output logic [1:0] mclk_ratio_sel,
    output logic [1:0] sample_rate_sel,
    output logic [2:0] input_format_sel,
    output ampctl_pkg::ampctl_fmt_t fmt_mode,
    output logic [4:0] fmt_width,
    output logic muted_pulse_ctrl,
    output logic modulation_index_sel,
    output logic noise_shaper_order,
    output logic [5:0] left_gain_eff,
    output logic [5:0] right_gain_eff,
    output logic left_stage_en,
    output logic right_stage_en,
    output logic amp_enable,
    output logic ocp_active,
    output logic otp_active
);
    import ampctl_pkg::*;

    typedef struct packed {
        ampctl_state_t state;
        logic [7:0] shift;
        logic [3:0] cnt;
        logic rw;
        logic [7:0] reg_addr;
        logic [7:0] last_addr;
        logic [7:0] input_reg;
        logic [7:0] left_ctl;
        logic [7:0] right_ctl;
        logic [7:0] misc;
        logic sda_oe;
        logic scl_prev;
        logic sda_prev;
        ampctl_fmt_t fmt;
        logic [4:0] width;
    } ampctl_top_t;

    ampctl_top_t q;
    ampctl_top_t d;
    logic [1:0] bus_s;
    logic scl_s;
    logic sda_s;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic [7:0] rdata;

    // Bus lines are asynchronous
    ampctl_sync #(.W(2), .INIT(2'h3)) u_bus_sync (
        .clk(sys_clk),
        .rst_n(rst_n),
        .d({scl_i, sda_i}),
        .q(bus_s)
    );
    assign scl_s = bus_s[1];
    assign sda_s = bus_s[0];

    // Register readback
    function automatic logic [7:0] read_reg(input ampctl_top_t s);
        unique case (s.reg_addr)
            REG_LAST_ADDR: read_reg = s.last_addr; // R11
            REG_INPUT: read_reg = s.input_reg; // R12
            REG_LEFT: read_reg = s.left_ctl; // R13
            REG_RIGHT: read_reg = s.right_ctl; // R13
            REG_MISC: read_reg = s.misc; // R20
            default: read_reg = 8'h00; // R10 R22
        endcase
    endfunction

    ///////////////////////////////////////////////////////////////////////////
    // Bus target and register file
    always_comb begin
        d = q;
        rdata = read_reg(q);

        // Edge detect
        d.scl_prev = scl_s;
        d.sda_prev = sda_s;
        rise = scl_s && !q.scl_prev;
        fall = !scl_s && q.scl_prev;
        start = scl_s && q.scl_prev && q.sda_prev && !sda_s; // R3
        stop = scl_s && q.scl_prev && !q.sda_prev && sda_s; // R4

        // Format decode, 111 acts as serial audio
        unique case (q.input_reg[FMT_LSB +: 3])
            3'h1: begin
                d.fmt = FMT_LEFT_MSB; // R18
                d.width = 5'h18;
            end

            3'h2: begin
                d.fmt = FMT_RIGHT_LSB; // R18
                d.width = 5'h18;
            end

            3'h3: begin
                d.fmt = FMT_RIGHT_MSB; // R18
                d.width = 5'h18;
            end

            3'h4: begin
                d.fmt = FMT_RIGHT_MSB; // R18
                d.width = 5'h14;
            end

            3'h5: begin
                d.fmt = FMT_RIGHT_MSB; // R18
                d.width = 5'h12;
            end

            3'h6: begin
                d.fmt = FMT_RIGHT_MSB; // R18
                d.width = 5'h10;
            end
            default: begin
                d.fmt = FMT_SERIAL_AUDIO; // R18
                d.width = RST_FMT_WIDTH;
            end
        endcase

        // Start and stop override any bit in progress
        if (start) begin
            d.state = ST_DEV; // R3
            d.cnt = 4'h0;
            d.sda_oe = 1'b0;
        end else if (stop) begin
            d.state = ST_IDLE; // R4
            d.sda_oe = 1'b0; // R2
        end else begin
            unique case (q.state)
                ST_IDLE: begin
                    d.sda_oe = 1'b0; // R2
                end

                ST_DEV, ST_REG, ST_WDATA: begin
                    if (rise && q.cnt != 4'h8) begin
                        d.shift = {q.shift[6:0], sda_s}; // R5
                        d.cnt = q.cnt + 4'h1;
                    end else if (fall && q.cnt == 4'h8) begin
                        d.sda_oe = 1'b1; // R5
                        if (q.state == ST_DEV) begin
                            // Foreign address: silent until next start
                            if (q.shift[7:1] == DEV_ADDR) begin
                                d.state = ST_DEV_ACK; // R7
                                d.rw = q.shift[0]; // R7
                            end else begin
                                d.state = ST_IDLE;
                                d.sda_oe = 1'b0;
                            end
                        end else if (q.state == ST_REG) begin
                            d.state = ST_REG_ACK; // R6
                            d.reg_addr = q.shift;
                            d.last_addr = q.shift; // R11
                        end else begin
                            d.state = ST_WDATA_ACK; // R6
                            unique case (q.reg_addr)
                                REG_INPUT: d.input_reg = q.shift & INPUT_WMASK; // R12
                                REG_LEFT: d.left_ctl = q.shift; // R13
                                REG_RIGHT: d.right_ctl = q.shift; // R13
                                REG_MISC: d.misc = (q.shift & MISC_WMASK) | MISC_FIXED; // R20
                                REG_SOFT_RESET: begin
                                    if (q.shift == SOFT_RESET_CODE) begin
                                        d.input_reg = RST_INPUT; // R10 R21
                                        d.left_ctl = RST_CHANNEL; // R10 R21
                                        d.right_ctl = RST_CHANNEL; // R10 R21
                                        d.misc = RST_MISC; // R10 R20
                                    end
                                end
                                default: d.misc = q.misc; // R22
                            endcase
                        end
                    end
                end

                ST_DEV_ACK: begin
                    if (fall) begin
                        if (q.rw) begin
                            // Read returns the register addressed by the dummy write
                            d.state = ST_TX; // R8
                            d.shift = rdata; // R8
                            d.sda_oe = !rdata[7]; // R8
                            d.cnt = 4'h1;
                        end else begin
                            d.state = ST_REG; // R6
                            d.sda_oe = 1'b0;
                            d.cnt = 4'h0;
                        end
                    end
                end

                ST_REG_ACK, ST_WDATA_ACK: begin
                    // Extra data bytes rewrite the same register
                    if (fall) begin
                        d.state = ST_WDATA;
                        d.sda_oe = 1'b0;
                        d.cnt = 4'h0;
                    end
                end

                ST_TX: begin
                    if (fall && q.cnt == 4'h8) begin
                        d.state = ST_TX_ACK; // R9
                        d.sda_oe = 1'b0;
                        d.cnt = 4'h0;
                    end else if (fall) begin
                        d.shift = {q.shift[6:0], 1'b0};
                        d.sda_oe = !q.shift[6]; // R8
                        d.cnt = q.cnt + 4'h1;
                    end
                end

                ST_TX_ACK: begin
                    if (rise) begin
                        // No acknowledge ends the read; wait for stop
                        if (sda_s) begin
                            d.state = ST_IDLE; // R9
                        end else begin
                            d.cnt = 4'h9;
                        end
                    end else if (fall && q.cnt == 4'h9) begin
                        d.state = ST_TX;
                        d.shift = rdata;
                        d.sda_oe = !rdata[7];
                        d.cnt = 4'h1;
                    end
                end
                default: begin
                    d.state = ST_IDLE;
                    d.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.state <= ST_IDLE;
            q.last_addr <= RST_LAST_ADDR;
            q.input_reg <= RST_INPUT; // R21
            q.left_ctl <= RST_CHANNEL; // R21
            q.right_ctl <= RST_CHANNEL; // R21
            q.misc <= RST_MISC; // R20
            // Idle high, so no false start
            q.scl_prev <= 1'b1;
            q.sda_prev <= 1'b1;
            q.fmt <= FMT_SERIAL_AUDIO;
            q.width <= RST_FMT_WIDTH;
        end else begin
            q <= d;
        end
    end

    ///////////////////////////////////////////////////////////////////////////
    // Protection and ramp
    ampctl_protect u_protect (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ocp_flag(ocp_flag),
        .otp_flag(otp_flag),
        .supply_ok(supply_ok),
        .left_ctl(q.left_ctl),
        .right_ctl(q.right_ctl),
        .left_gain_eff(left_gain_eff),
        .right_gain_eff(right_gain_eff),
        .left_stage_en(left_stage_en),
        .right_stage_en(right_stage_en),
        .amp_enable(amp_enable),
        .ocp_active(ocp_active),
        .otp_active(otp_active)
    );

    // Open drain: only ever pulls low
    assign sda_o = 1'b0; // R1
    assign sda_oe = q.sda_oe;

    // Register fields
    assign mclk_ratio_sel = q.input_reg[MCLK_LSB +: 2];
    assign sample_rate_sel = q.input_reg[SRATE_LSB +: 2];
    assign input_format_sel = q.input_reg[FMT_LSB +: 3];
    assign fmt_mode = q.fmt;
    assign fmt_width = q.width;
    assign muted_pulse_ctrl = q.misc[MISC_PULSE_BIT];
    assign modulation_index_sel = q.misc[MISC_MODIDX_BIT];
    assign noise_shaper_order = q.misc[MISC_NOISE_SHAPER_ORDER_BIT];
endmodule
`default_nettype wire

// file: verilog/ampctl_pkg.sv
// Constants, types and helpers of the amplifier control
//////////////////////////////////////////////////////////////////////////////
// What this block does
// R1: Two-wire bus target only, clock up to 100 kHz.
// R2: Idle bus: clock and data high, data released.
// R3: Data falling while clock high is a start.
// R4: Data rising while clock high is a stop.
// R5: Eight-bit bytes, each acknowledged by pulling data low.
// R6: Write: start, identifier, register address, data, stop.
// R7: Identifier: seven address bits, then direction; low writes.
// R8: Read: address dummy write, restart, identifier with read flag.
// R9: Master leaves read byte unacknowledged, then stops.
// R10: FFh is write-only; writing FFh restores all registers.
// R11: 00h is read-only, returns the last register address.
// R12: 10h: bit 7 zero, clock ratio, rate, format fields.
// R13: 20h/21h: disable bit 7, mute_n bit 6, gain 5:0.
// R14: Overcurrent turns the stage off about 20 us, then retries.
// R15: Overtemperature turns both stage halves off until clear.
// R16: Amplifier runs only while supply is reported good; the code keeps it on after supply loss until both gain ramps reach mute.
// R17: Undervoltage shutdown goes through the soft mute ramp.
// R18: Format codes: serial-audio, left, right LSB, right MSB widths.
// R19: Gain steps 1.5 dB; 110111 is 0 dB, zero mutes.
// R20: 30h: bit 0 reads one, bits 1 to 3 options.
// R21: After reset rate select 01, other fields zero, muted.
// R22: Unmapped addresses take writes silently, read zero.
//////////////////////////////////////////////////////////////////////////////
package ampctl_pkg;

    // Register addresses
    localparam logic [7:0] REG_LAST_ADDR = 8'h00;
    localparam logic [7:0] REG_INPUT = 8'h10;
    localparam logic [7:0] REG_LEFT = 8'h20;
    localparam logic [7:0] REG_RIGHT = 8'h21;
    localparam logic [7:0] REG_MISC = 8'h30;
    localparam logic [7:0] REG_SOFT_RESET = 8'hFF;
    localparam logic [7:0] SOFT_RESET_CODE = 8'hFF;

    // Field positions
    localparam int FMT_LSB = 0;
    localparam int SRATE_LSB = 3;
    localparam int MCLK_LSB = 5;
    localparam int CH_DISABLE_BIT = 7;
    localparam int CH_MUTE_N_BIT = 6;
    localparam int MISC_PULSE_BIT = 1;
    localparam int MISC_MODIDX_BIT = 2;
    localparam int MISC_NOISE_SHAPER_ORDER_BIT = 3;

    // Write masks and fixed bits
    localparam logic [7:0] INPUT_WMASK = 8'h7F;
    localparam logic [7:0] MISC_WMASK = 8'h0E;
    localparam logic [7:0] MISC_FIXED = 8'h01;

    // Values after reset
    localparam logic [7:0] RST_INPUT = 8'h08;
    localparam logic [7:0] RST_CHANNEL = 8'h00;
    localparam logic [7:0] RST_MISC = 8'h03;
    localparam logic [7:0] RST_LAST_ADDR = 8'h00;
    localparam logic [4:0] RST_FMT_WIDTH = 5'h18;

    // Gain codes
    localparam int GAIN_W = 6;
    localparam logic [5:0] GAIN_MUTED = 6'h00;
    localparam logic [5:0] GAIN_ZERO_DB = 6'h37;

    // Timing
    localparam int SYS_CLK_PERIOD_NS = 40;
    localparam int OCP_OFF_NS = 20000;
    localparam int OCP_OFF_CYCLES = OCP_OFF_NS / SYS_CLK_PERIOD_NS;
    localparam int OCP_CNT_W = 9;
    localparam int RAMP_STEP_CYCLES = 256;
    localparam int RAMP_CNT_W = 8;

    // Decoded audio input layout
    typedef enum logic [1:0] {
        FMT_SERIAL_AUDIO = 2'h0,
        FMT_LEFT_MSB = 2'h1,
        FMT_RIGHT_LSB = 2'h3,
        FMT_RIGHT_MSB = 2'h2
    } ampctl_fmt_t;

    // Two-wire target states, Gray along the write path
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_DEV = 4'h1,
        ST_DEV_ACK = 4'h3,
        ST_REG = 4'h2,
        ST_REG_ACK = 4'h6,
        ST_WDATA = 4'h7,
        ST_WDATA_ACK = 4'h5,
        ST_TX = 4'h4,
        ST_TX_ACK = 4'hC
    } ampctl_state_t;

    // One gain ramp step toward target
    function automatic logic [5:0] ampctl_step(input logic [5:0] cur, input logic [5:0] tgt);
        if (cur < tgt) begin
            ampctl_step = cur + 6'h01;
        end else if (cur > tgt) begin
            ampctl_step = cur - 6'h01;
        end else begin
            ampctl_step = cur;
        end
    endfunction

endpackage

// file: verilog/ampctl_sync.sv
// Two-stage synchroniser for asynchronous level inputs
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module ampctl_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ampctl_sync_t;

    ampctl_sync_t r_q;
    ampctl_sync_t r_d;

    // First stage feeds only the second stage
    always_comb begin
        r_d = r_q;
        r_d.s1 = d;
        r_d.s2 = r_q.s1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_q <= {INIT, INIT};
        end else begin
            r_q <= r_d;
        end
    end

    assign q = r_q.s2;
endmodule
`default_nettype wire

// file: verilog/ampctl_protect.sv
// Protection reactions and soft mute ramp
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module ampctl_protect (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ocp_flag,
    input wire logic otp_flag,
    input wire logic supply_ok,
    input wire logic [7:0] left_ctl,
    input wire logic [7:0] right_ctl,
    output logic [5:0] left_gain_eff,
    output logic [5:0] right_gain_eff,
    output logic left_stage_en,
    output logic right_stage_en,
    output logic amp_enable,
    output logic ocp_active,
    output logic otp_active
);
    import ampctl_pkg::*;

    typedef struct packed {
        logic [OCP_CNT_W-1:0] ocp_cnt;
        logic [RAMP_CNT_W-1:0] ramp_cnt;
        logic [5:0] gain_l;
        logic [5:0] gain_r;
        logic amp_on;
        logic otp;
        logic en_l;
        logic en_r;
        logic ocp;
    } ampctl_prot_t;

    ampctl_prot_t q;
    ampctl_prot_t d;
    logic [2:0] flags_s;
    logic ocp_s;
    logic otp_s;
    logic supply_s;
    logic [5:0] tgt_l;
    logic [5:0] tgt_r;
    logic step;

    // Comparators are asynchronous
    ampctl_sync #(.W(3), .INIT(3'h0)) u_flag_sync (
        .clk(sys_clk),
        .rst_n(rst_n),
        .d({ocp_flag, otp_flag, supply_ok}),
        .q(flags_s)
    );
    assign ocp_s = flags_s[2];
    assign otp_s = flags_s[1];
    assign supply_s = flags_s[0];

    always_comb begin
        d = q;
        // Retrigger only once window expired
        if (q.ocp_cnt != '0) begin
            d.ocp_cnt = q.ocp_cnt - OCP_CNT_W'(1); // R14
        end else if (ocp_s) begin
            d.ocp_cnt = OCP_CNT_W'(OCP_OFF_CYCLES); // R14
        end
        d.ocp = d.ocp_cnt != '0; // R14
        // Thermal trip follows the comparator, its hysteresis is analog
        d.otp = otp_s; // R15
        // Undervoltage ramps down like mute
        tgt_l = (!supply_s || !left_ctl[CH_MUTE_N_BIT]) ? GAIN_MUTED : left_ctl[5:0]; // R17
        tgt_r = (!supply_s || !right_ctl[CH_MUTE_N_BIT]) ? GAIN_MUTED : right_ctl[5:0]; // R17
        step = (q.ramp_cnt == RAMP_CNT_W'(RAMP_STEP_CYCLES - 1));
        d.ramp_cnt = step ? '0 : q.ramp_cnt + RAMP_CNT_W'(1);
        if (step) begin
            d.gain_l = ampctl_step(q.gain_l, tgt_l); // R19
            d.gain_r = ampctl_step(q.gain_r, tgt_r); // R19
        end
        // On after supply loss until both ramps muted
        d.amp_on = supply_s || (q.amp_on && (q.gain_l != GAIN_MUTED || q.gain_r != GAIN_MUTED)); // R16
        d.en_l = d.amp_on && d.ocp_cnt == '0 && !d.otp && !left_ctl[CH_DISABLE_BIT]; // R15
        d.en_r = d.amp_on && d.ocp_cnt == '0 && !d.otp && !right_ctl[CH_DISABLE_BIT]; // R15
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign left_gain_eff = q.gain_l;
    assign right_gain_eff = q.gain_r;
    assign left_stage_en = q.en_l;
    assign right_stage_en = q.en_r;
    assign amp_enable = q.amp_on;
    assign ocp_active = q.ocp;
    assign otp_active = q.otp;
endmodule
`default_nettype wire

// file: tb/ampctl_top_assertions.sv
// Port-level checker for the amplifier control block
`timescale 1ns/1ps
`default_nettype none
module ampctl_top_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic scl_i,
    input wire logic sda_oe,
    input wire logic otp_flag,
    input wire logic [2:0] input_format_sel,
    input wire logic [4:0] fmt_width,
    input wire logic [5:0] left_gain_eff,
    input wire logic [5:0] right_gain_eff,
    input wire logic left_stage_en,
    input wire logic right_stage_en,
    input wire logic amp_enable,
    input wire logic ocp_active,
    input wire logic otp_active
);
    // Slack for sync delay
    localparam int OCP_MIN = 498;
    localparam int OCP_MAX = 502;
    logic [9:0] ocp_len_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Length of overcurrent window
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ocp_len_q <= 10'h000;
        end else begin
            ocp_len_q <= ocp_active ? ocp_len_q + 10'h001 : 10'h000;
        end
    end
    //////////////////////////////////////////////////////////////////////////
    property p_sda_still; !$stable(sda_oe) |-> !scl_i; endproperty
    a_sda_still: assert property (p_sda_still) else $error("data moved with clock high");
    property p_ocp_off; ocp_active [*2] |-> !left_stage_en && !right_stage_en; endproperty
    a_ocp_off: assert property (p_ocp_off) else $error("stage on in ocp window");
    property p_ocp_len; $fell(ocp_active) |-> ocp_len_q >= OCP_MIN && ocp_len_q <= OCP_MAX;
    endproperty
    a_ocp_len: assert property (p_ocp_len) else $error("ocp window length wrong");
    property p_otp_on; otp_flag [*5] |-> otp_active && !left_stage_en; endproperty
    a_otp_on: assert property (p_otp_on) else $error("thermal shutdown missing");
    property p_amp_drop; $fell(amp_enable) |-> left_gain_eff == 6'h00 && right_gain_eff == 6'h00;
    endproperty
    a_amp_drop: assert property (p_amp_drop) else $error("amp off before ramp end");
    property p_stage_amp; !amp_enable [*2] |-> !left_stage_en && !right_stage_en; endproperty
    a_stage_amp: assert property (p_stage_amp) else $error("stage on with amp off");
    property p_gain_hold; !$stable(left_gain_eff) |=> $stable(left_gain_eff) [*8]; endproperty
    a_gain_hold: assert property (p_gain_hold) else $error("gain ramp too fast");
    property p_fmt_width; input_format_sel == 3'h4 |=> fmt_width == 5'h14; endproperty
    a_fmt_width: assert property (p_fmt_width) else $error("format width wrong");
endmodule
bind ampctl_top ampctl_top_checker u_ampctl_top_checker (.sys_clk, .rst_n, .scl_i, .sda_oe,
    .otp_flag, .input_format_sel, .fmt_width, .left_gain_eff, .right_gain_eff,
    .left_stage_en, .right_stage_en, .amp_enable, .ocp_active, .otp_active);
`default_nettype wire

// file: tb/ampctl_bus_model.sv
// Two-wire bus master model driving the amplifier control target
`timescale 1ns/1ps
`default_nettype none
module ampctl_bus_model (
    input wire logic sys_clk,
    input wire logic sda,
    output var logic scl,
    output var logic sda_pull
);
    // Quarter bit, 100 kHz clock
    localparam int QUARTER = 63;
    // Idle: lines released, pulled high
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic q();
        repeat (QUARTER) @(posedge sys_clk);
    endtask
    // Data falls with clock high; also used as restart
    task automatic start();
        sda_pull <= 1'b0;
        q();
        scl <= 1'b1;
        q();
        sda_pull <= 1'b1;
        q();
        scl <= 1'b0;
        q();
    endtask
    task automatic stop();
        sda_pull <= 1'b1;
        q();
        scl <= 1'b1;
        q();
        sda_pull <= 1'b0;
        q();
    endtask
    // Set with clock low, sampled mid high
    task automatic bitx(input logic b, output logic r);
        sda_pull <= !b;
        q();
        scl <= 1'b1;
        q();
        r = sda;
        q();
        scl <= 1'b0;
        q();
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
        end
        bitx(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, d[i]);
        end
        bitx(1'b1, r);
    endtask
endmodule
`default_nettype wire

// file: tb/tb_ampctl_top.sv
// Register and protection tests of the amplifier control
`timescale 1ns/1ps
`default_nettype none
module tb_ampctl_top;
    import ampctl_pkg::*;
    localparam logic [6:0] ADDR = 7'h2A;
    localparam logic [7:0] FX [7] = '{8'h18, 8'h38, 8'h78, 8'h58, 8'h54, 8'h52, 8'h50};
    logic sys_clk, scl_i, sda_i, sda_o, sda_oe, m_pull, amp_enable, ocp_active, otp_active;
    logic rst_n = 1'b0, ocp_flag = 1'b0, otp_flag = 1'b0, supply_ok = 1'b1;
    logic [1:0] mclk_ratio_sel, sample_rate_sel;
    logic [2:0] input_format_sel;
    ampctl_fmt_t fmt_mode;
    logic [4:0] fmt_width;
    logic muted_pulse_ctrl, modulation_index_sel, left_stage_en, right_stage_en;
    logic [5:0] left_gain_eff, right_gain_eff;
    int miscompares = 0;
    int checks = 0;
    // Open-drain data line with pull-up
    assign sda_i = !((sda_oe && !sda_o) || m_pull);
    ampctl_top u_ampctl_top (.sys_clk, .rst_n, .scl_i, .sda_i, .sda_o, .sda_oe, .ocp_flag,
        .otp_flag, .supply_ok, .mclk_ratio_sel, .sample_rate_sel, .input_format_sel, .fmt_mode,
        .fmt_width, .muted_pulse_ctrl, .modulation_index_sel, .noise_shaper_order(),
        .left_gain_eff, .right_gain_eff, .left_stage_en, .right_stage_en, .amp_enable,
        .ocp_active, .otp_active);
    ampctl_bus_model u_ampctl_bus_model (.sys_clk, .sda(sda_i), .scl(scl_i), .sda_pull(m_pull));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    //////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic hdr(input logic [7:0] ra, output logic [1:0] a);
        u_ampctl_bus_model.start();
        u_ampctl_bus_model.wbyte({ADDR, 1'b0}, a[1]);
        u_ampctl_bus_model.wbyte(ra, a[0]);
    endtask
    task automatic wr(input logic [7:0] ra, input logic [7:0] d);
        logic [2:0] a;
        hdr(ra, a[2:1]);
        u_ampctl_bus_model.wbyte(d, a[0]);
        u_ampctl_bus_model.stop();
        chk({5'h00, a}, 8'h07);
    endtask
    task automatic rd(input logic [7:0] ra, output logic [7:0] d);
        logic [2:0] a;
        hdr(ra, a[2:1]);
        u_ampctl_bus_model.start();
        u_ampctl_bus_model.wbyte({ADDR, 1'b1}, a[0]);
        u_ampctl_bus_model.rbyte(d);
        u_ampctl_bus_model.stop();
        chk({5'h00, a}, 8'h07);
    endtask
    task automatic results();
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Watchdog above the ~94k cycles of tests
    initial begin
        repeat (99000) @(posedge sys_clk);
        miscompares++;
        results();
    end
    initial begin
        logic [7:0] v;
        logic a;
        logic [1:0] h;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (30) @(posedge sys_clk);
        chk({sample_rate_sel, mclk_ratio_sel, 1'b0, input_format_sel}, 8'h40);
        chk({left_gain_eff, muted_pulse_ctrl, modulation_index_sel}, 8'h02);
        rd(REG_MISC, v);
        chk(v, 8'h03);
        // Foreign identifier gets no ack
        u_ampctl_bus_model.start();
        u_ampctl_bus_model.wbyte({~ADDR, 1'b0}, a);
        u_ampctl_bus_model.stop();
        chk({7'h00, a}, 8'h00);
        // Format codes 0 to 6, one transfer
        hdr(REG_INPUT, h);
        for (int i = 0; i < 7; i++) begin
            u_ampctl_bus_model.wbyte(8'(i), a);
            repeat (4) @(posedge sys_clk);
            chk({5'h00, input_format_sel}, 8'(i));
            chk({1'b0, fmt_mode, fmt_width}, FX[i]);
        end
        u_ampctl_bus_model.stop();
        wr(REG_INPUT, 8'hFF);
        rd(REG_INPUT, v);
        chk(v, 8'h7F);
        chk({4'h0, mclk_ratio_sel, sample_rate_sel}, 8'h0F);
        wr(REG_LEFT, 8'h43);
        wr(REG_RIGHT, 8'h80);
        repeat (900) @(posedge sys_clk);
        chk({left_stage_en, right_stage_en, left_gain_eff}, 8'h83);
        // Two overcurrent events
        for (int i = 0; i < 2; i++) begin
            ocp_flag <= 1'b1;
            repeat (10) @(posedge sys_clk);
            ocp_flag <= 1'b0;
            repeat (20) @(posedge sys_clk);
            chk({6'h00, ocp_active, left_stage_en}, 8'h02);
            repeat (500) @(posedge sys_clk);
            chk({6'h00, ocp_active, left_stage_en}, 8'h01);
        end
        otp_flag <= 1'b1;
        repeat (300) @(posedge sys_clk);
        chk({6'h00, otp_active, left_stage_en}, 8'h02);
        otp_flag <= 1'b0;
        repeat (10) @(posedge sys_clk);
        chk({6'h00, otp_active, left_stage_en}, 8'h01);
        supply_ok <= 1'b0;
        repeat (1000) @(posedge sys_clk);
        chk({1'b0, amp_enable, left_gain_eff}, 8'h00);
        supply_ok <= 1'b1;
        repeat (1000) @(posedge sys_clk);
        chk({1'b0, amp_enable, left_gain_eff}, 8'h43);
        wr(REG_SOFT_RESET, SOFT_RESET_CODE);
        repeat (1000) @(posedge sys_clk);
        chk({mclk_ratio_sel, sample_rate_sel, 3'h0, muted_pulse_ctrl}, 8'h11);
        chk({2'h0, left_gain_eff}, 8'h00);
        wr(8'h40, 8'h55);
        rd(8'h40, v);
        chk(v, 8'h00);
        results();
    end
endmodule
`default_nettype wire
